// ---- include/eqs_pkg.sv ----
// package of constants and types for the egress queue scheduler
package eqs_pkg;
  // register offsets within the qos page
  localparam logic [7:0] EQS_ADDR_CPU_MAP0 = 8'h64;
  localparam logic [7:0] EQS_ADDR_CPU_MAP3 = 8'h67;
  localparam logic [7:0] EQS_ADDR_SCHED_CTRL = 8'h80;
  localparam logic [7:0] EQS_ADDR_WEIGHT0 = 8'h81;
  localparam logic [7:0] EQS_ADDR_WEIGHT3 = 8'h84;
  localparam logic [7:0] EQS_ADDR_PRIO_MAP0 = 8'h62;
  localparam logic [7:0] EQS_ADDR_PRIO_MAP1 = 8'h63;
  // reset values
  localparam logic [31:0] EQS_RST_CPU_MAP = 32'h0000_0000;
  localparam logic [7:0] EQS_RST_SCHED_CTRL = 8'h00;
  localparam logic [7:0] EQS_RST_WEIGHT0 = 8'h01;
  localparam logic [7:0] EQS_RST_WEIGHT1 = 8'h02;
  localparam logic [7:0] EQS_RST_WEIGHT2 = 8'h04;
  localparam logic [7:0] EQS_RST_WEIGHT3 = 8'h08;
  localparam logic [15:0] EQS_RST_PRIO_MAP = 16'h0000;
  // class map field layout: writable bits, reason count, field width
  localparam logic [31:0] EQS_CPU_MAP_MASK = 32'h0003_FFFF;
  localparam int EQS_NUM_REASONS = 6;
  localparam int EQS_COS_W = 3;
  localparam int EQS_NUM_Q = 4;
  localparam int EQS_NUM_PRIO = 8;
  localparam logic [7:0] EQS_SCHED_SEL_MASK = 8'h03;
  // scheduling modes
  typedef enum logic [1:0] {
    EQS_MODE_ALL_WRR = 2'h0,
    EQS_MODE_Q3_SP = 2'h1,
    EQS_MODE_Q32_SP = 2'h2,
    EQS_MODE_ALL_SP = 2'h3
  } eqs_mode_t;
  // register access port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eqs_reg_req_t;
  // grant toward the egress transmit server
  typedef struct packed {
    logic valid;
    logic [1:0] queue;
  } eqs_grant_t;
endpackage

// ---- design/eqs_scheduler.sv ----
// egress class-of-service selection and four-queue transmit scheduler
// What this block does
// - six 3-bit cpu reason class values
// - multi-reason cpu packet takes highest class
// - 2-bit mode selects strict/weighted mix
// - strict queues served highest non-empty first
// - strict queues ignore service weights
// - weighted queues visited in rotation
// - 8-bit unsigned weight per queue, byte registers
// - weight N allows N packets per round
// - eight priorities map to queue by 2-bit field
`timescale 1ns/1ps
`default_nettype none
module eqs_scheduler (
  input wire logic core_clk, // 50 MHz core clock
  input wire logic rst_b, // async reset, active low
  input wire eqs_pkg::eqs_reg_req_t reg_req, // byte register access
  output logic [7:0] reg_rdata, // read data, registered
  input wire logic [5:0] cpu_reasons, // reasons a packet goes to cpu
  output logic [2:0] cpu_class, // class chosen for that packet
  input wire logic [2:0] prio_id, // priority of a packet
  output logic [1:0] prio_queue, // transmit queue for that priority
  input wire logic [3:0] queue_nonempty, // per-queue occupancy
  input wire logic tx_ready, // transmit server takes a grant
  output eqs_pkg::eqs_grant_t grant // queue to send one packet from
);
  import eqs_pkg::*;

  logic [31:0] cpu_map_reg;
  logic [7:0] sched_ctrl_reg;
  logic [7:0] weight_reg [EQS_NUM_Q];
  logic [15:0] prio_map_reg;
  logic [7:0] credit_reg [EQS_NUM_Q];
  logic [1:0] rr_ptr_reg;
  eqs_grant_t grant_reg;
  eqs_grant_t grant_next;
  logic [7:0] rdata_next;

  // byte-wise read/write decode, shared by read mux and write enables
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  wire logic [7:0] a = reg_req.addr;
  wire logic hit_cpu = in_range(a, EQS_ADDR_CPU_MAP0, EQS_ADDR_CPU_MAP3);
  wire logic hit_wgt = in_range(a, EQS_ADDR_WEIGHT0, EQS_ADDR_WEIGHT3);
  wire logic [1:0] cpu_byte = 2'(a - EQS_ADDR_CPU_MAP0);
  wire logic [1:0] wgt_idx = 2'(a - EQS_ADDR_WEIGHT0);
  wire logic [31:0] cpu_wr_val = ({24'h000000, reg_req.wdata} << {cpu_byte, 3'h0});
  wire logic [31:0] cpu_wr_en = (32'h0000_00FF << {cpu_byte, 3'h0});

  // register writes; reserved class map bits stay zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_map_reg <= EQS_RST_CPU_MAP;
      sched_ctrl_reg <= EQS_RST_SCHED_CTRL;
      weight_reg[0] <= EQS_RST_WEIGHT0;
      weight_reg[1] <= EQS_RST_WEIGHT1;
      weight_reg[2] <= EQS_RST_WEIGHT2;
      weight_reg[3] <= EQS_RST_WEIGHT3;
      prio_map_reg <= EQS_RST_PRIO_MAP;
    end else if (reg_req.wr) begin
      if (hit_cpu) begin
        cpu_map_reg <= ((cpu_map_reg & ~cpu_wr_en) | (cpu_wr_val & cpu_wr_en))
                       & EQS_CPU_MAP_MASK;
      end
      if (a == EQS_ADDR_SCHED_CTRL) begin
        sched_ctrl_reg <= reg_req.wdata;
      end
      if (hit_wgt) begin
        weight_reg[wgt_idx] <= reg_req.wdata;
      end
      if (a == EQS_ADDR_PRIO_MAP0) begin
        prio_map_reg[7:0] <= reg_req.wdata;
      end
      if (a == EQS_ADDR_PRIO_MAP1) begin
        prio_map_reg[15:8] <= reg_req.wdata;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit_cpu) begin
      rdata_next = 8'(cpu_map_reg >> {cpu_byte, 3'h0});
    end else if (a == EQS_ADDR_SCHED_CTRL) begin
      rdata_next = sched_ctrl_reg;
    end else if (hit_wgt) begin
      rdata_next = weight_reg[wgt_idx];
    end else if (a == EQS_ADDR_PRIO_MAP0) begin
      rdata_next = prio_map_reg[7:0];
    end else if (a == EQS_ADDR_PRIO_MAP1) begin
      rdata_next = prio_map_reg[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // cpu class: max over asserted reasons; bit k of reasons uses field k
  always_comb begin
    cpu_class = 3'h0;
    for (int k = 0; k < EQS_NUM_REASONS; k++) begin
      if (cpu_reasons[k] && (cpu_map_reg[k*EQS_COS_W +: EQS_COS_W] > cpu_class)) begin
        cpu_class = cpu_map_reg[k*EQS_COS_W +: EQS_COS_W];
      end
    end
  end

  // priority to queue lookup, combinational
  assign prio_queue = prio_map_reg[{prio_id, 1'b0} +: 2];

  // strict set per mode: bit q set when queue q is strict
  eqs_mode_t mode;
  logic [3:0] strict_set;
  assign mode = eqs_mode_t'(sched_ctrl_reg[1:0]);
  always_comb begin
    case (mode)
      EQS_MODE_ALL_WRR: strict_set = 4'h0;
      EQS_MODE_Q3_SP: strict_set = 4'h8;
      EQS_MODE_Q32_SP: strict_set = 4'hC;
      EQS_MODE_ALL_SP: strict_set = 4'hF;
      default: strict_set = 4'h0;
    endcase
  end

  wire logic [3:0] strict_ready = strict_set & queue_nonempty;

  // grant handshake with the transmit server
  wire logic take = grant_reg.valid && tx_ready;
  wire logic load = !grant_reg.valid || tx_ready;
  // a taken weighted grant spends credit; strict grants never do
  wire logic spend = take && !strict_set[grant_reg.queue];

  // credit and pointer as they stand after this edge's take;
  // the next grant is chosen from these so a spent queue is not
  // granted once more while its decrement is still in flight
  logic [7:0] credit_eff [EQS_NUM_Q];
  logic [1:0] ptr_eff;
  always_comb begin
    for (int q = 0; q < EQS_NUM_Q; q++) begin
      credit_eff[q] = credit_reg[q];
      if (spend && (grant_reg.queue == 2'(q))) begin
        credit_eff[q] = credit_reg[q] - 8'h01;
      end
    end
  end
  // pointer steps past a queue as its last credit goes
  assign ptr_eff = (spend && (credit_reg[grant_reg.queue] == 8'h01))
                   ? 2'(grant_reg.queue + 2'h1) : rr_ptr_reg;

  // weighted candidates: nonempty with credit left
  logic [3:0] wrr_ready;
  logic [3:0] wrr_active;
  always_comb begin
    for (int q = 0; q < EQS_NUM_Q; q++) begin
      wrr_active[q] = !strict_set[q] && queue_nonempty[q];
      wrr_ready[q] = wrr_active[q] && (credit_eff[q] != 8'h00);
    end
  end
  // round over once every active weighted queue is out of credit
  wire logic round_done = (wrr_active != 4'h0) && (wrr_ready == 4'h0);

  // choose next grant: strict first, then rotation from pointer
  always_comb begin
    grant_next.valid = 1'b0;
    grant_next.queue = 2'h0;
    if (strict_ready != 4'h0) begin
      grant_next.valid = 1'b1;
      for (int q = 0; q < EQS_NUM_Q; q++) begin
        if (strict_ready[q]) begin
          grant_next.queue = 2'(q);
        end
      end
    end else begin
      for (int i = EQS_NUM_Q - 1; i >= 0; i--) begin
        if (wrr_ready[2'(ptr_eff + 2'(i))]) begin
          grant_next.valid = 1'b1;
          grant_next.queue = 2'(ptr_eff + 2'(i));
        end
      end
    end
  end

  // grant register holds until the transmit server takes it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      grant_reg <= '0;
    end else if (load) begin
      grant_reg <= round_done ? eqs_grant_t'('0) : grant_next;
    end
  end
  assign grant = grant_reg;

  // credits: a taken weighted grant spends one; refill at round end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      credit_reg[0] <= EQS_RST_WEIGHT0;
      credit_reg[1] <= EQS_RST_WEIGHT1;
      credit_reg[2] <= EQS_RST_WEIGHT2;
      credit_reg[3] <= EQS_RST_WEIGHT3;
      rr_ptr_reg <= 2'h0;
    end else if (round_done) begin
      for (int q = 0; q < EQS_NUM_Q; q++) begin
        credit_reg[q] <= weight_reg[q];
      end
      rr_ptr_reg <= 2'h0;
    end else if (spend) begin
      credit_reg[grant_reg.queue] <= credit_eff[grant_reg.queue];
      rr_ptr_reg <= ptr_eff;
    end
  end
endmodule // eqs_scheduler
`default_nettype wire

// ---- test/eqs_chk_assertions.sv ----
// port checker for the egress queue scheduler
`timescale 1ns/1ps
`default_nettype none
module eqs_chk (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire eqs_pkg::eqs_reg_req_t reg_req, // access
  input wire logic [7:0] reg_rdata, // read
  input wire logic [5:0] cpu_reasons, // reasons
  input wire logic [2:0] cpu_class, // class
  input wire logic [3:0] queue_nonempty, // demand
  input wire logic tx_ready, // taken
  input wire eqs_pkg::eqs_grant_t grant // grant
);
  import eqs_pkg::*;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // grant loaded at the last edge, not one held over a stall
  sequence fresh_s;
    grant.valid && $past(tx_ready || !grant.valid);
  endsequence
  // weight write, idle, read of the same byte
  sequence wr_rd_s;
    reg_req.wr && reg_req.addr > 8'h80 && reg_req.addr < 8'h85 ##1 !reg_req.wr
      ##1 reg_req.rd && reg_req.addr == $past(reg_req.addr, 2);
  endsequence
  a_grant_holds: assert property (grant.valid && !tx_ready |=> $stable(grant))
    else $error("grant moved");
  a_grant_demand: assert property (fresh_s
    |-> (($past(queue_nonempty) >> grant.queue) & 4'h1) != 4'h0) else $error("empty grant");
  a_idle_quiet: assert property (queue_nonempty == 4'h0 && !grant.valid |=> !grant.valid)
    else $error("idle grant");
  a_rdata_stands: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  a_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h90 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_top_byte: assert property (reg_req.rd && reg_req.addr == EQS_ADDR_CPU_MAP3
    |=> reg_rdata == 8'h00) else $error("top byte");
  a_weight_back: assert property (wr_rd_s |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("weight read");
  a_no_reason: assert property (cpu_reasons == 6'h00 |-> cpu_class == 3'h0)
    else $error("class no reason");
endmodule // eqs_chk
bind eqs_scheduler eqs_chk eqs_chk_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .cpu_reasons(cpu_reasons), .cpu_class(cpu_class),
  .queue_nonempty(queue_nonempty), .tx_ready(tx_ready), .grant(grant));
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the egress queue scheduler
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eqs_pkg::*;
  logic core_clk, rst_b, tx_ready;
  logic [7:0] reg_rdata;
  logic [5:0] cpu_reasons;
  logic [2:0] cpu_class;
  logic [2:0] prio_id;
  logic [1:0] prio_queue;
  logic [3:0] queue_nonempty;
  eqs_reg_req_t reg_req;
  eqs_grant_t grant;
  int err_count = 0;
  int samples_checked = 0;
  eqs_scheduler eqs_scheduler_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .cpu_reasons(cpu_reasons), .cpu_class(cpu_class), .prio_id(prio_id),
    .prio_queue(prio_queue), .queue_nonempty(queue_nonempty), .tx_ready(tx_ready), .grant(grant));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one access; an idle cycle follows so strobes never toggle twice at one edge
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_req = '{r, !r, a, d};
    @(negedge core_clk);
    reg_req = '0;
    @(negedge core_clk);
    if (r) cmp("reg_rdata", {8'h00, d}, {8'h00, reg_rdata});
  endtask
  // records taken grants, two bits each, first in the low bits
  task automatic run(input logic [1:0] m, input logic [3:0] ne, input logic [15:0] e);
    logic [15:0] g;
    int k;
    acc(1'b0, EQS_ADDR_SCHED_CTRL, {6'h00, m});
    g = '0;
    k = 0;
    queue_nonempty = ne;
    tx_ready = 1'b0;
    // stall first so a held grant is exercised
    repeat (3) @(negedge core_clk);
    tx_ready = 1'b1;
    for (int c = 0; c < 40 && k < 8; c++) begin
      if (grant.valid === 1'b1) begin
        g[2*k +: 2] = grant.queue;
        k++;
      end
      @(negedge core_clk);
    end
    queue_nonempty = 4'h0;
    repeat (3) @(negedge core_clk);
    cmp("grant order", e, g);
  endtask
  task automatic cls(input logic [5:0] r, input logic [2:0] e);
    cpu_reasons = r;
    #1 cmp("cpu_class", {13'h0, e}, {13'h0, cpu_class});
    @(negedge core_clk);
  endtask
  task automatic pq(input logic [2:0] p, input logic [1:0] e);
    prio_id = p;
    #1 cmp("prio_queue", {14'h0, e}, {14'h0, prio_queue});
    @(negedge core_clk);
  endtask
  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    tx_ready = 1'b0;
    cpu_reasons = 6'h00;
    prio_id = 3'h0;
    queue_nonempty = 4'h0;
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) acc(1'b1, 8'(8'h81 + i), 8'(8'h01 << i));
    acc(1'b1, EQS_ADDR_SCHED_CTRL, 8'h00);
    pq(3'h7, 2'h0);
    acc(1'b0, EQS_ADDR_PRIO_MAP0, 8'hE4);
    acc(1'b0, EQS_ADDR_PRIO_MAP1, 8'hC0);
    for (int i = 0; i < 4; i++) pq(3'(i), 2'(i));
    pq(3'h4, 2'h0);
    pq(3'h7, 2'h3);
    run(2'h0, 4'h3, 16'h4514);
    run(2'h3, 4'h5, 16'hAAAA);
    run(2'h1, 4'hB, 16'hFFFF);
    run(2'h2, 4'h6, 16'hAAAA);
    acc(1'b0, EQS_ADDR_WEIGHT3, 8'h31);
    acc(1'b1, EQS_ADDR_WEIGHT3, 8'h31);
    acc(1'b0, EQS_ADDR_SCHED_CTRL, 8'hFC);
    acc(1'b1, EQS_ADDR_SCHED_CTRL, 8'hFC);
    acc(1'b0, 8'h90, 8'h5A);
    acc(1'b1, 8'h90, 8'h00);
    // classes 1..6 from mirror up; bits above 17 must stay zero
    for (int i = 0; i < 4; i++) acc(1'b0, 8'(8'h64 + i), 8'(32'hFFFF58D1 >> (8 * i)));
    for (int i = 0; i < 4; i++) acc(1'b1, 8'(8'h64 + i), 8'(32'h000358D1 >> (8 * i)));
    for (int i = 0; i < 6; i++) cls(6'(6'h01 << i), 3'(i + 1));
    cls(6'h05, 3'h3);
    cls(6'h3F, 3'h6);
    cls(6'h00, 3'h0);
    close_out();
  end
  // watchdog well beyond the fewer than 150 cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    close_out();
  end
endmodule // tb
`default_nettype wire
